// >>> pkg/psh_map.svh
/*
  Register offsets, field positions, reset values and timing counts of the
  pulse selection and histogram block. Assumes a 200 MHz system clock.
*/
`ifndef PSH_MAP_SVH
`define PSH_MAP_SVH

`define PSH_OFS_CTRL        8'h00
`define PSH_OFS_FAST_THR    8'h04
`define PSH_OFS_SLOW_THR    8'h08
`define PSH_OFS_HW_LIMIT    8'h0C
`define PSH_OFS_DISC_FLOOR  8'h10
`define PSH_OFS_SHAPE       8'h14
`define PSH_OFS_FAST_CNT    8'h18
`define PSH_OFS_SLOW_CNT    8'h1C
`define PSH_OFS_ACQ_TIME    8'h20
`define PSH_OFS_HIST_ADDR   8'h24
`define PSH_OFS_HIST_DATA   8'h28
`define PSH_OFS_STATUS      8'h2C

`define PSH_CTRL_RUN        0
`define PSH_CTRL_PILE_EN    1
`define PSH_CTRL_DISC_EN    2
`define PSH_CTRL_GATE_LO    3
`define PSH_CTRL_GATE_HI    4
`define PSH_CTRL_LEN_LO     5
`define PSH_CTRL_LEN_HI     7
`define PSH_CTRL_BUF_SW     8
`define PSH_CTRL_BUF_HW     9
`define PSH_CTRL_RESET      10'h000

`define PSH_SHAPE_RESET     32'h0004_0008
`define PSH_THR_RESET       16'h0000
`define PSH_LIMIT_RESET     16'h0010

`define PSH_CLK_NS          5
`define PSH_PAIR_RES_NS     600
`define PSH_PAIR_RES_CYC    ((`PSH_PAIR_RES_NS + `PSH_CLK_NS - 1) / `PSH_CLK_NS)
`define PSH_JITTER_DIV      5
`define PSH_CNT_MAX         24'hFFFFFF
`define PSH_LEN_MAX_SEL     3'h5
`define PSH_LEN_RS232_SEL   3'h4
`define PSH_LEN_BASE_LOG2   8

`endif

// >>> pkg/psh_pkg.sv
/*
  Types of the pulse selection and histogram block.
  Assumes psh_map.svh for all numeric constants.
*/
package psh_pkg;

  typedef enum logic [1:0] {
    PSH_GATE_OFF = 2'b00,
    PSH_GATE_HIGH = 2'b01,
    PSH_GATE_LOW = 2'b10
  } psh_gate_e;

  typedef enum logic {
    PSH_SLOW_IDLE = 1'b0,
    PSH_SLOW_RISE = 1'b1
  } psh_slow_e;

  typedef struct packed {
    logic [15:0] amp;
    logic [15:0] half_width;
    logic        gate_ok;
    logic        fast_ok;
    logic        piled;
  } psh_event_s;

  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } psh_bus_s;

endpackage : psh_pkg

// >>> core/psh_core.sv
/*
  Pulse selection and histogramming core: fast/slow pile-up rejection,
  rise-time discrimination, low-level discriminator, gate and a two-buffer
  multichannel histogrammer held in flip-flops.
  Assumes shaped slow samples and fast-channel samples arrive one per clock,
  synchronous to i_sys_clk, with trapezoidal shaping done upstream.

  // Overview of operation
  // - Fast channel runs beside slow channel.
  // - Peak capture adds no dead time.
  // - Interval is rise plus 20% plus flat.
  // - Rejection off: piled pulse stored once.
  // - Rejection on: both piled events discarded.
  // - Only fast threshold crossings trigger pile-up.
  // - Sub-threshold partner events escape rejection.
  // - Half width compared with programmable limit.
  // - Below discrimination floor bypasses rise-time check.
  // - Rise-time check rejects missing fast trigger.
  // - Rise-time check rejects too-wide pulses.
  // - Peaks below slow threshold are ignored.
  // - Gate disabled, active high or low.
  // - Gated off stops acquisition time clock.
  // - Fast count needs gate at trigger.
  // - Slow count needs gate at peak.
  // - Length 256 to 8192 channels.
  // - 8192 channels only over USB link.
  // - Three-byte counter per channel.
  // - Buffer A/B by software or pin.
  // - Rise and flat top are programmable.
*/
`timescale 1ns/10ps
`default_nettype none
`include "psh_map.svh"

module psh_core #(
  parameter int AW       = 16,
  parameter int MAX_LOG2 = 13
) (
  input  wire logic              i_sys_clk,
  input  wire logic              i_rst,
  input  wire logic [AW-1:0]     i_slow_sample,
  input  wire logic [AW-1:0]     i_fast_sample,
  input  wire logic              i_gate,
  input  wire logic              i_buf_sel,
  input  wire logic              i_host_usb,
  input  wire psh_pkg::psh_bus_s i_bus,
  output var  logic [31:0]       o_rdata,
  output var  logic              o_event_accept,
  output var  logic              o_event_reject,
  output var  logic              o_fast_trig
);
  import psh_pkg::*;

  localparam int DEPTH = 1 << MAX_LOG2;

  logic [9:0]       ctrl_reg;
  logic [15:0]      fast_thr_reg;
  logic [15:0]      slow_thr_reg;
  logic [15:0]      hw_limit_reg;
  logic [15:0]      disc_floor_reg;
  logic [31:0]      shape_reg;
  logic [31:0]      fast_cnt_reg;
  logic [31:0]      slow_cnt_reg;
  logic [31:0]      acq_time_reg;
  logic [MAX_LOG2:0] hist_addr_reg;
  logic [23:0]      hist_mem [0:2*DEPTH-1];

  logic             gate_ok;
  logic             run;
  logic [17:0]      interval;
  logic [2:0]       len_sel;
  logic             act_buf;

  logic             fast_above_reg;
  logic [AW-1:0]    fast_peak_reg;
  logic [15:0]      half_cnt_reg;
  logic [15:0]      half_width_reg;
  logic             fast_trig;
  logic             trig_seen_reg;
  logic [17:0]      since_trig_reg;
  logic             pile_now;
  logic [17:0]      pile_hold_reg;

  psh_slow_e        slow_state_reg;
  logic [AW-1:0]    slow_prev_reg;
  logic             peak_det;

  psh_event_s       pend_reg;
  logic             pend_valid_reg;
  logic [17:0]      pend_cnt_reg;
  logic             commit;
  logic             accept;
  logic [MAX_LOG2-1:0] bin;
  logic [MAX_LOG2:0]   ev_addr;

  always_comb begin
    run = ctrl_reg[`PSH_CTRL_RUN];
    unique case (psh_gate_e'(ctrl_reg[`PSH_CTRL_GATE_HI:`PSH_CTRL_GATE_LO]))
      PSH_GATE_HIGH: gate_ok = i_gate;
      PSH_GATE_LOW:  gate_ok = ~i_gate;
      default:       gate_ok = 1'b1;
    endcase
  end

  // The jitter margin is a fifth of the rise time, truncated to whole cycles.
  always_comb begin
    interval = {2'b00, shape_reg[15:0]}
             + 18'(shape_reg[15:0] / `PSH_JITTER_DIV)
             + {2'b00, shape_reg[31:16]};
  end

  // The top setting folds back to 4096 channels on the serial port link.
  always_comb begin
    len_sel = ctrl_reg[`PSH_CTRL_LEN_HI:`PSH_CTRL_LEN_LO];
    if (len_sel > `PSH_LEN_MAX_SEL) begin
      len_sel = `PSH_LEN_RS232_SEL;
    end
    if (len_sel == `PSH_LEN_MAX_SEL && !i_host_usb) begin
      len_sel = `PSH_LEN_RS232_SEL;
    end
    act_buf = ctrl_reg[`PSH_CTRL_BUF_HW] ? i_buf_sel : ctrl_reg[`PSH_CTRL_BUF_SW];
  end

  // Fast channel: threshold crossing, peak and half of the width at half maximum.
  always_comb begin
    fast_trig = (i_fast_sample > fast_thr_reg) && !fast_above_reg;
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      fast_above_reg <= 1'b0;
      fast_peak_reg  <= '0;
      half_cnt_reg   <= 16'h0000;
      half_width_reg <= 16'h0000;
    end else begin
      fast_above_reg <= i_fast_sample > fast_thr_reg;
      if (fast_trig) begin
        fast_peak_reg <= i_fast_sample;
        half_cnt_reg  <= 16'h0001;
      end else if (fast_above_reg) begin
        if (i_fast_sample > fast_peak_reg) begin
          fast_peak_reg <= i_fast_sample;
        end
        if (i_fast_sample >= (fast_peak_reg >> 1) && half_cnt_reg != 16'hFFFF) begin
          half_cnt_reg <= half_cnt_reg + 16'h0001;
        end
        if (i_fast_sample <= fast_thr_reg) begin
          half_width_reg <= half_cnt_reg >> 1;
        end
      end
    end
  end

  // Pile-up timing: a trigger past the pair resolution but inside the interval.
  always_comb begin
    pile_now = fast_trig && trig_seen_reg
             && (since_trig_reg > 18'(`PSH_PAIR_RES_CYC))
             && (since_trig_reg < interval);
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      trig_seen_reg  <= 1'b0;
      since_trig_reg <= 18'h00000;
      pile_hold_reg  <= 18'h00000;
    end else begin
      if (fast_trig) begin
        trig_seen_reg  <= 1'b1;
        since_trig_reg <= 18'h00000;
      end else if (since_trig_reg != 18'h3FFFF) begin
        since_trig_reg <= since_trig_reg + 18'h00001;
      end
      if (pile_now) begin
        pile_hold_reg <= interval;
      end else if (pile_hold_reg != 18'h00000) begin
        pile_hold_reg <= pile_hold_reg - 18'h00001;
      end
    end
  end

  // Slow channel peak detect; the peak is taken on the fly, so no extra dead time.
  always_comb begin
    peak_det = (slow_state_reg == PSH_SLOW_RISE) && (i_slow_sample < slow_prev_reg)
             && (slow_prev_reg >= slow_thr_reg);
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      slow_state_reg <= PSH_SLOW_IDLE;
      slow_prev_reg  <= '0;
    end else begin
      slow_prev_reg <= i_slow_sample;
      unique case (slow_state_reg)
        PSH_SLOW_IDLE: begin
          if (i_slow_sample > slow_prev_reg) begin
            slow_state_reg <= PSH_SLOW_RISE;
          end
        end
        PSH_SLOW_RISE: begin
          if (i_slow_sample < slow_prev_reg) begin
            slow_state_reg <= PSH_SLOW_IDLE;
          end
        end
      endcase
    end
  end

  // A peak waits one interval before binning so a later partner can still
  // reject it; a new peak forces the waiting one out early.
  always_comb begin
    commit = pend_valid_reg && (pend_cnt_reg == 18'h00000 || peak_det);
    accept = pend_reg.gate_ok
           && !(ctrl_reg[`PSH_CTRL_PILE_EN] && pend_reg.piled);
    if (ctrl_reg[`PSH_CTRL_DISC_EN] && pend_reg.amp >= disc_floor_reg) begin
      if (!pend_reg.fast_ok) begin
        accept = 1'b0;
      end else if (pend_reg.half_width > hw_limit_reg) begin
        accept = 1'b0;
      end
    end
    bin = MAX_LOG2'(pend_reg.amp >> (AW - `PSH_LEN_BASE_LOG2 - int'(len_sel)));
    ev_addr = {act_buf, bin};
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      pend_valid_reg <= 1'b0;
      pend_cnt_reg   <= 18'h00000;
      pend_reg       <= '0;
    end else begin
      if (peak_det && run) begin
        pend_valid_reg   <= 1'b1;
        pend_cnt_reg     <= interval;
        pend_reg.amp     <= 16'(slow_prev_reg);
        pend_reg.half_width <= half_width_reg;
        pend_reg.gate_ok <= gate_ok;
        pend_reg.fast_ok <= trig_seen_reg && since_trig_reg < interval;
        pend_reg.piled   <= pile_now || pile_hold_reg != 18'h00000;
      end else begin
        if (commit) begin
          pend_valid_reg <= 1'b0;
        end else if (pend_valid_reg) begin
          pend_cnt_reg <= pend_cnt_reg - 18'h00001;
        end
        if (pile_now) begin
          pend_reg.piled <= 1'b1;
        end
      end
    end
  end

  // Rate counters; the acquisition clock stops with the gate.
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      fast_cnt_reg <= 32'h0000_0000;
      slow_cnt_reg <= 32'h0000_0000;
      acq_time_reg <= 32'h0000_0000;
    end else begin
      if (run && fast_trig && gate_ok) begin
        fast_cnt_reg <= fast_cnt_reg + 32'h0000_0001;
      end
      if (commit && accept) begin
        slow_cnt_reg <= slow_cnt_reg + 32'h0000_0001;
      end
      if (run && gate_ok) begin
        acq_time_reg <= acq_time_reg + 32'h0000_0001;
      end
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      o_event_accept <= 1'b0;
      o_event_reject <= 1'b0;
      o_fast_trig    <= 1'b0;
    end else begin
      o_event_accept <= commit && accept;
      o_event_reject <= commit && !accept;
      o_fast_trig    <= fast_trig;
    end
  end

  // Histogram storage. A host write to the same word wins over an event.
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      for (int i = 0; i < 2 * DEPTH; i++) begin
        hist_mem[i] <= 24'h000000;
      end
    end else begin
      if (commit && accept && hist_mem[ev_addr] != `PSH_CNT_MAX) begin
        hist_mem[ev_addr] <= hist_mem[ev_addr] + 24'h000001;
      end
      if (i_bus.wr && i_bus.addr == `PSH_OFS_HIST_DATA) begin
        hist_mem[hist_addr_reg] <= i_bus.wdata[23:0];
      end
    end
  end

  // Configuration registers and the auto-incrementing histogram pointer.
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      ctrl_reg       <= `PSH_CTRL_RESET;
      fast_thr_reg   <= `PSH_THR_RESET;
      slow_thr_reg   <= `PSH_THR_RESET;
      hw_limit_reg   <= `PSH_LIMIT_RESET;
      disc_floor_reg <= `PSH_THR_RESET;
      shape_reg      <= `PSH_SHAPE_RESET;
      hist_addr_reg  <= '0;
    end else begin
      if (i_bus.wr) begin
        unique case (i_bus.addr)
          `PSH_OFS_CTRL:       ctrl_reg       <= i_bus.wdata[9:0];
          `PSH_OFS_FAST_THR:   fast_thr_reg   <= i_bus.wdata[15:0];
          `PSH_OFS_SLOW_THR:   slow_thr_reg   <= i_bus.wdata[15:0];
          `PSH_OFS_HW_LIMIT:   hw_limit_reg   <= i_bus.wdata[15:0];
          `PSH_OFS_DISC_FLOOR: disc_floor_reg <= i_bus.wdata[15:0];
          `PSH_OFS_SHAPE:      shape_reg      <= i_bus.wdata;
          `PSH_OFS_HIST_ADDR:  hist_addr_reg  <= i_bus.wdata[MAX_LOG2:0];
          `PSH_OFS_HIST_DATA:  hist_addr_reg  <= hist_addr_reg + 1'b1;
          default: ;
        endcase
      end else if (i_bus.rd && i_bus.addr == `PSH_OFS_HIST_DATA) begin
        hist_addr_reg <= hist_addr_reg + 1'b1;
      end
    end
  end

  // Read data stand for one cycle after the strobe; unmapped words read zero.
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      o_rdata <= 32'h0000_0000;
    end else if (i_bus.rd) begin
      unique case (i_bus.addr)
        `PSH_OFS_CTRL:       o_rdata <= {22'h000000, ctrl_reg};
        `PSH_OFS_FAST_THR:   o_rdata <= {16'h0000, fast_thr_reg};
        `PSH_OFS_SLOW_THR:   o_rdata <= {16'h0000, slow_thr_reg};
        `PSH_OFS_HW_LIMIT:   o_rdata <= {16'h0000, hw_limit_reg};
        `PSH_OFS_DISC_FLOOR: o_rdata <= {16'h0000, disc_floor_reg};
        `PSH_OFS_SHAPE:      o_rdata <= shape_reg;
        `PSH_OFS_FAST_CNT:   o_rdata <= fast_cnt_reg;
        `PSH_OFS_SLOW_CNT:   o_rdata <= slow_cnt_reg;
        `PSH_OFS_ACQ_TIME:   o_rdata <= acq_time_reg;
        `PSH_OFS_HIST_ADDR:  o_rdata <= 32'(hist_addr_reg);
        `PSH_OFS_HIST_DATA:  o_rdata <= {8'h00, hist_mem[hist_addr_reg]};
        `PSH_OFS_STATUS:     o_rdata <= {26'h0000000, len_sel, pend_valid_reg,
                                         gate_ok, act_buf};
        default:             o_rdata <= 32'h0000_0000;
      endcase
    end else begin
      o_rdata <= 32'h0000_0000;
    end
  end

endmodule : psh_core
`default_nettype wire

// >>> test/psh_core_checker.sv
/*
  Concurrent checks on the ports of the pulse selection and histogram core.
  Assumes it is bound to every instance of psh_core and sees only its ports.
*/
`timescale 1ns/10ps
`default_nettype none

module psh_core_checker #(
  parameter int AW       = 16,
  parameter int MAX_LOG2 = 13
) (
  input wire logic              i_sys_clk,
  input wire logic              i_rst,
  input wire logic [AW-1:0]     i_fast_sample,
  input wire logic              i_host_usb,
  input wire psh_pkg::psh_bus_s i_bus,
  input wire logic [31:0]       o_rdata,
  input wire logic              o_event_accept,
  input wire logic              o_event_reject,
  input wire logic              o_fast_trig
);
  import psh_pkg::*;

  default clocking dcb @(posedge i_sys_clk);
  endclocking
  default disable iff (i_rst);

  rdata_idle_a: assert property (
    !$past(i_bus.rd) |-> o_rdata == 32'h0) else $error("read data outside read slot");
  unmapped_zero_a: assert property (
    $past(i_bus.rd) && ($past(i_bus.addr) > 8'h2C) |-> o_rdata == 32'h0)
    else $error("unmapped read not zero");
  hist_width_a: assert property (
    $past(i_bus.rd) && ($past(i_bus.addr) == 8'h28) |-> o_rdata[31:24] == 8'h0)
    else $error("histogram word wider than three bytes");
  len_range_a: assert property (
    $past(i_bus.rd) && ($past(i_bus.addr) == 8'h2C) |-> o_rdata[5:3] <= 3'h5)
    else $error("length select out of range");
  serial_len_a: assert property (
    $past(i_bus.rd) && ($past(i_bus.addr) == 8'h2C) && !$past(i_host_usb)
    |-> o_rdata[5:3] <= 3'h4) else $error("longest histogram on serial link");
  decision_excl_a: assert property (
    !(o_event_accept && o_event_reject)) else $error("event accepted and rejected");
  trig_pulse_a: assert property (
    o_fast_trig |=> !o_fast_trig) else $error("fast trigger longer than one cycle");
  trig_cause_a: assert property (
    o_fast_trig |-> ($past(i_fast_sample) != '0) || ($past(i_fast_sample, 2) != '0))
    else $error("fast trigger without fast signal");

endmodule : psh_core_checker

bind psh_core psh_core_checker #(.AW(AW), .MAX_LOG2(MAX_LOG2)) i_chk (
  .i_sys_clk, .i_rst, .i_fast_sample, .i_host_usb, .i_bus,
  .o_rdata, .o_event_accept, .o_event_reject, .o_fast_trig);

`default_nettype wire

// >>> test/psh_front_end.sv
/*
  Behavioural model of the shaped detector front end: a triangular slow pulse
  and a rectangular fast pulse, each started by a one-cycle request.
  Assumes requests arrive synchronous to i_sys_clk.
*/
`timescale 1ns/10ps
`default_nettype none

module psh_front_end (
  input  wire logic        i_sys_clk,
  input  wire logic        i_rst,
  input  wire logic        i_slow_go,
  input  wire logic [15:0] i_slow_amp,
  input  wire logic [15:0] i_slow_rise,
  input  wire logic        i_fast_go,
  input  wire logic [15:0] i_fast_h,
  input  wire logic [15:0] i_fast_w,
  output var  logic [15:0] o_slow_sample,
  output var  logic [15:0] o_fast_sample
);
  int          k_slow;
  int          k_fast;
  int          amp_reg;
  int          rise_reg;
  logic [15:0] h_reg;

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      k_slow   <= -1;
      amp_reg  <= 0;
      rise_reg <= 1;
    end else if (i_slow_go) begin
      k_slow   <= 0;
      amp_reg  <= i_slow_amp;
      rise_reg <= i_slow_rise;
    end else if (k_slow >= 0 && k_slow < 2 * rise_reg) begin
      k_slow <= k_slow + 1;
    end else begin
      k_slow <= -1;
    end
  end

  // Rise and fall take the same number of cycles, as the shaper keeps them equal.
  always_comb begin
    if (k_slow < 0) begin
      o_slow_sample = 16'h0000;
    end else if (k_slow <= rise_reg) begin
      o_slow_sample = 16'(amp_reg * k_slow / rise_reg);
    end else begin
      o_slow_sample = 16'(amp_reg * (2 * rise_reg - k_slow) / rise_reg);
    end
  end

  // The fast channel runs beside the slow one and may retrigger at any time.
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      k_fast <= 0;
      h_reg  <= 16'h0000;
    end else if (i_fast_go) begin
      k_fast <= i_fast_w;
      h_reg  <= i_fast_h;
    end else if (k_fast > 0) begin
      k_fast <= k_fast - 1;
    end
  end

  assign o_fast_sample = (k_fast > 0) ? h_reg : 16'h0000;

endmodule : psh_front_end

`default_nettype wire

// >>> test/pulse_selection_histogram_test.sv
/*
  Self-checking testbench of the pulse selection and histogram core.
  Assumes the front-end model drives both sample streams and the bench the bus.
*/
`timescale 1ns/10ps
`default_nettype none
`include "psh_map.svh"

module pulse_selection_histogram_test;
  import psh_pkg::*;

  logic        clk, rst, gate, bsel, usb, acc, rej, trig, sgo, fgo;
  logic [15:0] slow, fast, samp, srise, fh, fw;
  logic [31:0] rdata, d, d2, ctrl;
  psh_bus_s    bus;
  int          n_errors, num_checks, n_acc, n_rej, exp_fast, a;
  int          seed = 32'hc2f6dc2a;
  bit   [23:0] hist [16384];

  psh_core i_dut (.i_sys_clk(clk), .i_rst(rst), .i_slow_sample(slow), .i_fast_sample(fast),
    .i_gate(gate), .i_buf_sel(bsel), .i_host_usb(usb), .i_bus(bus), .o_rdata(rdata),
    .o_event_accept(acc), .o_event_reject(rej), .o_fast_trig(trig));
  psh_front_end i_fe (.i_sys_clk(clk), .i_rst(rst), .i_slow_go(sgo), .i_slow_amp(samp),
    .i_slow_rise(srise), .i_fast_go(fgo), .i_fast_h(fh), .i_fast_w(fw),
    .o_slow_sample(slow), .o_fast_sample(fast));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  always @(posedge clk) if (acc === 1'b1) n_acc <= n_acc + 1;
  always @(posedge clk) if (rej === 1'b1) n_rej <= n_rej + 1;

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic wr(input logic [7:0] ad, input logic [31:0] wd);
    @(posedge clk); bus <= '{ad, wd, 1'b1, 1'b0};
    @(posedge clk); bus.wr <= 1'b0;
  endtask : wr

  // Read data are taken just after the edge that launched them, where they stand.
  task automatic rd(input logic [7:0] ad, output logic [31:0] rv);
    @(posedge clk); bus <= '{ad, 32'h0, 1'b0, 1'b1};
    @(posedge clk); bus.rd <= 1'b0;
    #1 rv = rdata;
  endtask : rd

  task automatic setc(input logic [31:0] v);
    ctrl = v;
    wr(`PSH_OFS_CTRL, v);
  endtask : setc

  function automatic bit gate_ok();
    return (ctrl[4:3] == 2'b01) ? gate : (ctrl[4:3] == 2'b10) ? !gate : 1'b1;
  endfunction : gate_ok

  // A serial host link caps the length at 4096 channels.
  function automatic logic [2:0] eff();
    return (ctrl[7:5] > 3'h5 || (ctrl[7:5] == 3'h5 && !usb)) ? 3'h4 : ctrl[7:5];
  endfunction : eff

  function automatic logic [13:0] key(input logic [15:0] amp);
    return {ctrl[9] ? bsel : ctrl[8], 13'(amp >> (4'd8 - eff()))};
  endfunction : key

  task automatic pulse(input logic [15:0] amp, r, w, h, input int sep, input bit ex);
    logic [13:0] k;
    int          n0;
    int          r0;
    k = key(amp);
    n0 = n_acc;
    r0 = n_rej;
    @(posedge clk); samp <= amp; srise <= r; fw <= w; fh <= h; sgo <= 1'b1; fgo <= (w != 0);
    if (w != 0 && h > 16'h0800 && gate_ok()) exp_fast++;
    @(posedge clk); sgo <= 1'b0; fgo <= 1'b0;
    if (sep > 0) begin
      repeat (sep[12:0] - 1) @(posedge clk);
      fh <= sep[15:0] & 16'h2000 | 16'h0400; fgo <= 1'b1;
      if (sep[13] && gate_ok()) exp_fast++;
      @(posedge clk); fgo <= 1'b0;
    end
    repeat (3 * r + 120) @(posedge clk);
    check("accepts", n_acc - n0, ex);
    check("rejects", n_rej - r0, !ex && amp >= 16'h0100);
    if (ex && hist[k] != 24'hFFFFFF) hist[k]++;
    wr(`PSH_OFS_HIST_ADDR, {18'h0, k});
    rd(`PSH_OFS_HIST_DATA, d);
    check("bin", d, {8'h0, hist[k]});
  endtask : pulse

  task automatic end_of_test();
    $display("Checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : end_of_test

  initial begin
    repeat (40000) @(posedge clk);
    n_errors++;
    end_of_test();
  end

  // A second fast pulse is coded in sep: bit 13 set means above the fast threshold.
  initial begin
    rst = 1'b1; gate = 1'b0; bsel = 1'b0; usb = 1'b1; bus = '0; ctrl = '0;
    sgo = 1'b0; fgo = 1'b0; samp = '0; srise = 16'h1; fh = '0; fw = '0;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    rd(`PSH_OFS_CTRL, d); check("ctrl", d, 32'h0);
    rd(`PSH_OFS_SHAPE, d); check("shape", d, `PSH_SHAPE_RESET);
    rd(`PSH_OFS_HW_LIMIT, d); check("limit", d, 32'h10);
    rd(8'h30, d); check("unmapped", d, 32'h0);
    wr(`PSH_OFS_FAST_THR, 32'h800); wr(`PSH_OFS_SLOW_THR, 32'h100);
    wr(`PSH_OFS_SHAPE, 32'h0028_0008); wr(`PSH_OFS_DISC_FLOOR, 32'h4000);
    setc(32'h1);
    pulse(16'h0080, 8, 0, 0, 0, 0);
    for (int i = 0; i < 7; i++) begin
      a = $random(seed);
      usb <= (i != 6);
      bsel <= a[0];
      setc(32'h1 | (32'(i > 5 ? 5 : i) << 5) | (a & 32'h300));
      pulse(a[31:16] | 16'h1000, 8, 0, 0, 0, 1);
      rd(`PSH_OFS_STATUS, d);
      check("status", {d[5:3], d[0]}, {eff(), (ctrl[9] ? bsel : ctrl[8])});
    end
    wr(`PSH_OFS_HIST_ADDR, {18'h0, key(16'hC000)}); wr(`PSH_OFS_HIST_DATA, 32'hFFFFFF);
    hist[key(16'hC000)] = 24'hFFFFFF;
    pulse(16'hC000, 8, 0, 0, 0, 1);
    for (int m = 0; m < 8; m++) begin
      gate <= m[0];
      setc(32'h1 | (m[2:1] << 3));
      rd(`PSH_OFS_ACQ_TIME, d); rd(`PSH_OFS_ACQ_TIME, d2);
      check("acq time", d2 - d, gate_ok() ? 32'h2 : 32'h0);
      // The gate is held across the whole pulse, longer than peaking plus flat top.
      pulse(16'h1000 | 16'($random(seed)), 8, 20, 16'h2000, 0, gate_ok());
    end
    rd(`PSH_OFS_FAST_CNT, d); check("fast count", d, exp_fast);
    setc(32'h5);
    pulse(16'h2000, 8, 0, 0, 0, 1);
    pulse(16'h8000, 8, 0, 0, 0, 0);
    // The fast response must end before the slow peak, so the slow rise is made long here.
    pulse(16'h8000, 40, 20, 16'h2000, 0, 1);
    pulse(16'h8000, 40, 32, 16'h2000, 0, 1);
    pulse(16'h8000, 40, 34, 16'h2000, 0, 0);
    wr(`PSH_OFS_SHAPE, 32'h000A_00C8);
    setc(32'h3);
    pulse(16'h3000, 200, 10, 16'h2000, 150 | 32'h2000, 0);
    pulse(16'h3000, 200, 10, 16'h2000, 150, 1);
    pulse(16'h3000, 200, 10, 16'h2000, 100 | 32'h2000, 1);
    setc(32'h1);
    pulse(16'h3000, 200, 10, 16'h2000, 150 | 32'h2000, 1);
    rd(`PSH_OFS_FAST_CNT, d); check("fast count", d, exp_fast);
    end_of_test();
  end

endmodule : pulse_selection_histogram_test

`default_nettype wire
